// file: rtl/ter_pkg.sv
package ter_pkg;

	// Special-register numbers of the three registers
	localparam logic [9:0] TER_SPR_STATUS  = 10'h3d8;
	localparam logic [9:0] TER_SPR_CONTROL = 10'h3da;
	localparam logic [9:0] TER_SPR_COUNTER = 10'h3db;

	// Control field positions (software bit 0 is word bit 31)
	localparam int unsigned TER_CTL_WDPER_LSB = 30;
	localparam int unsigned TER_CTL_WDRST_LSB = 28;
	localparam int unsigned TER_CTL_WDIRQEN   = 27;
	localparam int unsigned TER_CTL_IVIRQEN   = 26;
	localparam int unsigned TER_CTL_FPER_LSB  = 24;
	localparam int unsigned TER_CTL_FXIRQEN   = 23;
	localparam int unsigned TER_CTL_ARE       = 22;

	// Status field positions
	localparam int unsigned TER_STS_ARM       = 31;
	localparam int unsigned TER_STS_WDIRQ     = 30;
	localparam int unsigned TER_STS_WDRST_LSB = 28;
	localparam int unsigned TER_STS_IVIRQ     = 27;
	localparam int unsigned TER_STS_FXIRQ     = 26;

	// Reset values
	localparam logic [31:0] TER_CONTROL_RESET = 32'h0000_0000;
	localparam logic [31:0] TER_COUNTER_RESET = 32'h0000_0000;
	localparam logic [1:0]  TER_FLAG_RESET    = 2'h0;
	localparam logic [1:0]  TER_WDRST_RESET   = 2'h0;

	// Selected time-base bit, little-endian index: base + 4 * period code
	localparam logic [4:0] TER_WD_BIT_BASE    = 5'h10;
	localparam logic [4:0] TER_FIXED_BIT_BASE = 5'h08;

	typedef enum logic [1:0] {
		TER_RST_NONE   = 2'h0,
		TER_RST_CORE   = 2'h1,
		TER_RST_CHIP   = 2'h2,
		TER_RST_SYSTEM = 2'h3
	} ter_reset_type;

endpackage

// file: rtl/ter_tb_if.sv
`timescale 1ns/1ps
interface ter_tb_if;
	logic [31:0] timeBaseLow;
	logic [1:0]  wdPeriod;
	logic [1:0]  fixedPeriod;
	logic        wdTimeout;
	logic        fixedTick;

	modport source (
		output timeBaseLow,
		output wdPeriod,
		output fixedPeriod,
		input  wdTimeout,
		input  fixedTick
	);

	modport detector (
		input  timeBaseLow,
		input  wdPeriod,
		input  fixedPeriod,
		output wdTimeout,
		output fixedTick
	);
endinterface

// file: rtl/ter_tb_edges.sv
`timescale 1ns/1ps
module ter_tb_edges
	import ter_pkg::*;
(
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	// Time-base taps
	ter_tb_if.detector tb
);

	logic [31:0] prevBase_q;
	logic [31:0] prevBase_d;
	logic        primed_q;
	logic        primed_d;
	logic        wdBit;
	logic        wdPrevBit;
	logic        fixedBit;
	logic        fixedPrevBit;

	function automatic logic tbSel(input logic [31:0] baseWord,
			input logic [1:0] code, input logic [4:0] base);
		logic [4:0] idx;
		idx = 5'(base + {1'b0, code, 2'b00});
		return baseWord[idx];
	endfunction

	// Old and new values are both read through the current period, so a
	// period change alone never looks like a 0-to-1 step
	always_comb begin
		wdBit        = tbSel(tb.timeBaseLow, tb.wdPeriod,
			TER_WD_BIT_BASE);
		wdPrevBit    = tbSel(prevBase_q, tb.wdPeriod,
			TER_WD_BIT_BASE);
		fixedBit     = tbSel(tb.timeBaseLow, tb.fixedPeriod,
			TER_FIXED_BIT_BASE);
		fixedPrevBit = tbSel(prevBase_q, tb.fixedPeriod,
			TER_FIXED_BIT_BASE);
		prevBase_d   = tb.timeBaseLow;
		primed_d     = 1'b1;
	end

	// No edge is reported in the first cycle after reset: the history is
	// not yet valid
	assign tb.wdTimeout = primed_q & wdBit & ~wdPrevBit;
	assign tb.fixedTick = primed_q & fixedBit & ~fixedPrevBit;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prevBase_q <= 32'h0000_0000;
			primed_q   <= 1'b0;
		end else begin
			prevBase_q <= prevBase_d;
			primed_q   <= primed_d;
		end
	end

endmodule

// file: rtl/ter_timer_events.sv
// Behaviour
// - 32-bit interval counter decrements per time-base tick
// - Tick at count one raises interval event
// - Auto-reload reloads last written value, never zero
// - Without reload: steps to zero, holds there
// - Reset clears auto-reload enable
// - Control bits 0:1 pick watchdog period
// - Control bits 2:3 pick watchdog reset kind
// - Reset-kind bits settable, cleared only by reset
// - Control bit 4 enables watchdog interrupt
// - Control bit 5 enables interval interrupt
// - Control bits 6:7 pick fixed-interval period
// - Control bit 8 enables fixed-interval interrupt
// - Control bit 9 auto-reload; rest reserved
// - Status write clears bits written as one
// - Hardware sets status; software only clears
// - Status bit 0 arms the watchdog
// - Status bit 1 records watchdog interrupt
// - Status bits 2:3 report watchdog-caused reset
// - Status bit 4 set by interval event
// - Status bit 5 fixed-interval event; rest reserved
// - Watchdog timeout on selected bit rising
// - Armed with interrupt recorded: force selected reset
`timescale 1ns/1ps
module ter_timer_events
	import ter_pkg::*;
(
	// Clock and resets
	input  wire logic                   sys_clk,
	input  wire logic                   rst_n,
	input  wire logic                   porRst_n,
	// Special-register moves
	input  wire logic [9:0]             sprNum,
	input  wire logic                   sprWrEn,
	input  wire logic [31:0]            sprWrData,
	input  wire logic                   sprRdEn,
	output logic [31:0]                 sprRdData,
	output logic                        sprRdValid,
	// Time base
	input  wire logic [31:0]            timeBaseLow,
	input  wire logic                   timeBaseTick,
	// Event pulses
	output logic                        intervalEvent,
	output logic                        wdTimeoutEvent,
	output logic                        fixedEvent,
	// Interrupt and reset requests
	output logic                        watchdogIrq,
	output logic                        intervalIrq,
	output logic                        fixedIrq,
	output logic                        wdResetReq,
	output ter_pkg::ter_reset_type      wdResetKind
);
	import ter_pkg::*;

	ter_tb_if tbBus ();

	// Control fields
	logic [1:0]  wdPeriod_q,    wdPeriod_d;
	logic [1:0]  wdResetCtl_q,  wdResetCtl_d;
	logic        wdIrqEn_q,     wdIrqEn_d;
	logic        intIrqEn_q,    intIrqEn_d;
	logic [1:0]  fixedPeriod_q, fixedPeriod_d;
	logic        fixedIrqEn_q,  fixedIrqEn_d;
	logic        autoReload_q,  autoReload_d;
	// Status fields
	logic        armNextWd_q,   armNextWd_d;
	logic        wdIrqSts_q,    wdIrqSts_d;
	logic [1:0]  wdResetSts_q,  wdResetSts_d;
	logic        intIrqSts_q,   intIrqSts_d;
	logic        fixedIrqSts_q, fixedIrqSts_d;
	// Counter
	logic [31:0] count_q,       count_d;
	logic [31:0] reload_q,      reload_d;
	// Read port and reset request
	logic [31:0] rdData_q,      rdData_d;
	logic        rdValid_q,     rdValid_d;
	logic        resetReq_q,    resetReq_d;
	ter_reset_type resetKind_q, resetKind_d;

	logic        wrCtl;
	logic        wrSts;
	logic        wrCnt;
	logic        intervalFire;
	logic        wdForce;
	logic [31:0] ctlWord;
	logic [31:0] stsWord;

	function automatic logic isWrite(input logic en, input logic [9:0] num,
			input logic [9:0] target);
		return en && (num == target);
	endfunction

	function automatic logic clearBit(input logic cur, input logic en,
			input logic mask);
		return cur & ~(en & mask);
	endfunction

	assign wrCtl = isWrite(sprWrEn, sprNum, TER_SPR_CONTROL);
	assign wrSts = isWrite(sprWrEn, sprNum, TER_SPR_STATUS);
	assign wrCnt = isWrite(sprWrEn, sprNum, TER_SPR_COUNTER);

	assign tbBus.timeBaseLow = timeBaseLow;
	assign tbBus.wdPeriod    = wdPeriod_q;
	assign tbBus.fixedPeriod = fixedPeriod_q;

	ter_tb_edges u_edges (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.tb      (tbBus)
	);

	// Register images; reserved bits read as zero
	always_comb begin
		ctlWord = 32'h0000_0000;
		ctlWord[TER_CTL_WDPER_LSB +: 2] = wdPeriod_q;
		ctlWord[TER_CTL_WDRST_LSB +: 2] = wdResetCtl_q;
		ctlWord[TER_CTL_WDIRQEN]        = wdIrqEn_q;
		ctlWord[TER_CTL_IVIRQEN]        = intIrqEn_q;
		ctlWord[TER_CTL_FPER_LSB +: 2]  = fixedPeriod_q;
		ctlWord[TER_CTL_FXIRQEN]        = fixedIrqEn_q;
		ctlWord[TER_CTL_ARE]            = autoReload_q;
		stsWord = 32'h0000_0000;
		stsWord[TER_STS_ARM]            = armNextWd_q;
		stsWord[TER_STS_WDIRQ]          = wdIrqSts_q;
		stsWord[TER_STS_WDRST_LSB +: 2] = wdResetSts_q;
		stsWord[TER_STS_IVIRQ]          = intIrqSts_q;
		stsWord[TER_STS_FXIRQ]          = fixedIrqSts_q;
	end

	// Control register
	always_comb begin
		wdPeriod_d    = wdPeriod_q;
		wdResetCtl_d  = wdResetCtl_q;
		wdIrqEn_d     = wdIrqEn_q;
		intIrqEn_d    = intIrqEn_q;
		fixedPeriod_d = fixedPeriod_q;
		fixedIrqEn_d  = fixedIrqEn_q;
		autoReload_d  = autoReload_q;
		if (wrCtl) begin
			wdPeriod_d    = sprWrData[TER_CTL_WDPER_LSB +: 2];
			// Sticky OR: a runaway program cannot switch forced resets off
			wdResetCtl_d  = wdResetCtl_q
				| sprWrData[TER_CTL_WDRST_LSB +: 2];
			wdIrqEn_d     = sprWrData[TER_CTL_WDIRQEN];
			intIrqEn_d    = sprWrData[TER_CTL_IVIRQEN];
			fixedPeriod_d = sprWrData[TER_CTL_FPER_LSB +: 2];
			fixedIrqEn_d  = sprWrData[TER_CTL_FXIRQEN];
			autoReload_d  = sprWrData[TER_CTL_ARE];
		end
	end

	// Interval counter; a write in the same cycle as a tick wins
	always_comb begin
		count_d  = count_q;
		reload_d = reload_q;
		intervalFire = 1'b0;
		if (wrCnt) begin
			count_d  = sprWrData;
			reload_d = sprWrData;
		end else if (timeBaseTick && count_q != 32'h0000_0000) begin
			if (count_q == 32'h0000_0001) begin
				intervalFire = 1'b1;
				count_d = autoReload_q ? reload_q
					: 32'h0000_0000;
			end else begin
				count_d = 32'(count_q - 32'h0000_0001);
			end
		end
	end

	// Watchdog decision on a timeout
	assign wdForce = tbBus.wdTimeout && armNextWd_q && wdIrqSts_q
		&& (wdResetCtl_q != 2'h0);

	// Status register: hardware set wins over a software clear
	always_comb begin
		armNextWd_d   = clearBit(armNextWd_q, wrSts,
			sprWrData[TER_STS_ARM]);
		wdIrqSts_d    = clearBit(wdIrqSts_q, wrSts,
			sprWrData[TER_STS_WDIRQ]);
		wdResetSts_d  = wdResetSts_q
			& ~({2{wrSts}} & sprWrData[TER_STS_WDRST_LSB +: 2]);
		intIrqSts_d   = clearBit(intIrqSts_q, wrSts,
			sprWrData[TER_STS_IVIRQ]);
		fixedIrqSts_d = clearBit(fixedIrqSts_q, wrSts,
			sprWrData[TER_STS_FXIRQ]);
		if (tbBus.wdTimeout) begin
			if (!armNextWd_q) begin
				armNextWd_d = 1'b1;
			end else if (!wdIrqSts_q) begin
				wdIrqSts_d = 1'b1;
			end else if (wdForce) begin
				wdResetSts_d = wdResetCtl_q;
			end
		end
		if (intervalFire) begin
			intIrqSts_d = 1'b1;
		end
		if (tbBus.fixedTick) begin
			fixedIrqSts_d = 1'b1;
		end
	end

	// Read port; unknown register numbers read as zero
	always_comb begin
		rdValid_d = sprRdEn;
		rdData_d  = rdData_q;
		if (sprRdEn) begin
			case (sprNum)
				TER_SPR_STATUS: begin
					rdData_d = stsWord;
				end
				TER_SPR_CONTROL: begin
					rdData_d = ctlWord;
				end
				TER_SPR_COUNTER: begin
					rdData_d = count_q;
				end
				default: begin
					rdData_d = 32'h0000_0000;
				end
			endcase
		end
	end

	// Forced-reset request; the kind stays latched for software
	always_comb begin
		resetReq_d  = wdForce;
		resetKind_d = resetKind_q;
		if (wdForce) begin
			resetKind_d = ter_reset_type'(wdResetCtl_q);
		end
	end

	assign sprRdData      = rdData_q;
	assign sprRdValid     = rdValid_q;
	assign intervalEvent  = intervalFire;
	assign wdTimeoutEvent = tbBus.wdTimeout;
	assign fixedEvent     = tbBus.fixedTick;
	assign watchdogIrq    = armNextWd_q & wdIrqSts_q & wdIrqEn_q;
	assign intervalIrq    = intIrqSts_q & intIrqEn_q;
	assign fixedIrq       = fixedIrqSts_q & fixedIrqEn_q;
	assign wdResetReq     = resetReq_q;
	assign wdResetKind    = resetKind_q;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wdPeriod_q    <= TER_CONTROL_RESET[TER_CTL_WDPER_LSB +: 2];
			wdResetCtl_q  <= TER_CONTROL_RESET[TER_CTL_WDRST_LSB +: 2];
			wdIrqEn_q     <= TER_CONTROL_RESET[TER_CTL_WDIRQEN];
			intIrqEn_q    <= TER_CONTROL_RESET[TER_CTL_IVIRQEN];
			fixedPeriod_q <= TER_CONTROL_RESET[TER_CTL_FPER_LSB +: 2];
			fixedIrqEn_q  <= TER_CONTROL_RESET[TER_CTL_FXIRQEN];
			autoReload_q  <= TER_CONTROL_RESET[TER_CTL_ARE];
		end else begin
			wdPeriod_q    <= wdPeriod_d;
			wdResetCtl_q  <= wdResetCtl_d;
			wdIrqEn_q     <= wdIrqEn_d;
			intIrqEn_q    <= intIrqEn_d;
			fixedPeriod_q <= fixedPeriod_d;
			fixedIrqEn_q  <= fixedIrqEn_d;
			autoReload_q  <= autoReload_d;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_q  <= TER_COUNTER_RESET;
			reload_q <= TER_COUNTER_RESET;
		end else begin
			count_q  <= count_d;
			reload_q <= reload_d;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			armNextWd_q   <= TER_FLAG_RESET[0];
			wdIrqSts_q    <= TER_FLAG_RESET[0];
			intIrqSts_q   <= TER_FLAG_RESET[0];
			fixedIrqSts_q <= TER_FLAG_RESET[0];
		end else begin
			armNextWd_q   <= armNextWd_d;
			wdIrqSts_q    <= wdIrqSts_d;
			intIrqSts_q   <= intIrqSts_d;
			fixedIrqSts_q <= fixedIrqSts_d;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData_q   <= 32'h0000_0000;
			rdValid_q  <= 1'b0;
			resetReq_q <= 1'b0;
		end else begin
			rdData_q   <= rdData_d;
			rdValid_q  <= rdValid_d;
			resetReq_q <= resetReq_d;
		end
	end

	// Reset cause survives the forced reset: power-on clears it, a status write clears only status bits 2:3
	always_ff @(posedge sys_clk or negedge porRst_n) begin
		if (!porRst_n) begin
			wdResetSts_q <= TER_WDRST_RESET;
			resetKind_q  <= TER_RST_NONE;
		end else begin
			wdResetSts_q <= wdResetSts_d;
			resetKind_q  <= resetKind_d;
		end
	end

endmodule

// file: sim/ter_time_base_model.sv
`timescale 1ns/1ps
module ter_time_base_model (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// Bench controls
	input  wire logic        tickEn,
	input  wire logic        tbLoad,
	input  wire logic [31:0] tbLoadVal,
	// Time base
	output logic [31:0]      timeBaseLow,
	output logic             timeBaseTick
);
	logic [31:0] timeBaseLow_q;
	logic [31:0] timeBaseLow_d;

	// Preload lets a far bit rise without waiting out the real period
	always_comb begin
		timeBaseLow_d = timeBaseLow_q + {31'h0, tickEn};
		if (tbLoad) begin
			timeBaseLow_d = tbLoadVal;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			timeBaseLow_q <= 32'h0;
		end else begin
			timeBaseLow_q <= timeBaseLow_d;
		end
	end

	assign timeBaseLow  = timeBaseLow_q;
	assign timeBaseTick = tickEn;
endmodule

// file: sim/ter_timer_events_props.sv
`timescale 1ns/1ps
module ter_timer_events_props
	import ter_pkg::*;
(
	// Clock and reset
	input wire logic          sys_clk,
	input wire logic          rst_n,
	// Register moves
	input wire logic [9:0]    sprNum,
	input wire logic          sprWrEn,
	// Time base and events
	input wire logic [31:0]   timeBaseLow,
	input wire logic          timeBaseTick,
	input wire logic          intervalEvent,
	input wire logic          wdTimeoutEvent,
	input wire logic          fixedEvent,
	// Requests
	input wire logic          watchdogIrq,
	input wire logic          intervalIrq,
	input wire logic          fixedIrq,
	input wire logic          wdResetReq,
	input wire ter_reset_type wdResetKind
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	ivl_tick_a:
		assert property (intervalEvent |-> timeBaseTick)
		else $error("interval event without tick");
	ivl_load_a:
		assert property (intervalEvent |->
			!(sprWrEn && sprNum == TER_SPR_COUNTER))
		else $error("interval event during counter load");
	wd_rise_a:
		assert property (wdTimeoutEvent |->
			|(timeBaseLow & ~$past(timeBaseLow) & 32'h1111_0000))
		else $error("watchdog event without bit rise");
	fixed_rise_a:
		assert property (fixedEvent |->
			|(timeBaseLow & ~$past(timeBaseLow) & 32'h0011_1100))
		else $error("fixed event without bit rise");
	ivl_irq_a:
		assert property ($rose(intervalIrq) |->
			$past(intervalEvent) || $past(sprWrEn))
		else $error("interval request without cause");
	wd_irq_a:
		assert property ($rose(watchdogIrq) |->
			$past(wdTimeoutEvent) || $past(sprWrEn))
		else $error("watchdog request without cause");
	irq_clear_a:
		assert property ($fell(intervalIrq) || $fell(fixedIrq) |->
			$past(sprWrEn))
		else $error("request dropped without write");
	rst_req_a:
		assert property (wdResetReq |->
			$past(wdTimeoutEvent) && wdResetKind != TER_RST_NONE)
		else $error("reset request without cause");
	rst_pulse_a:
		assert property (wdResetReq |=> !wdResetReq)
		else $error("reset request longer than a cycle");

	ivl_evt_c:   cover property (intervalEvent);
	fixed_irq_c: cover property ($rose(fixedIrq));
	wd_rst_c:    cover property (wdResetReq);
endmodule

bind ter_timer_events ter_timer_events_props u_props (
	.sys_clk(sys_clk), .rst_n(rst_n), .sprNum(sprNum),
	.sprWrEn(sprWrEn), .timeBaseLow(timeBaseLow),
	.timeBaseTick(timeBaseTick), .intervalEvent(intervalEvent),
	.wdTimeoutEvent(wdTimeoutEvent), .fixedEvent(fixedEvent),
	.watchdogIrq(watchdogIrq), .intervalIrq(intervalIrq),
	.fixedIrq(fixedIrq), .wdResetReq(wdResetReq),
	.wdResetKind(wdResetKind)
);

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import ter_pkg::*;
	logic          sys_clk, rst_n, porRst_n, sprWrEn, sprRdEn;
	logic          tickEn, tbLoad, sprRdValid, timeBaseTick;
	logic          intervalEvent, wdTimeoutEvent, fixedEvent;
	logic          watchdogIrq, intervalIrq, fixedIrq, wdResetReq;
	logic [9:0]    sprNum;
	logic [31:0]   sprWrData, sprRdData, tbLoadVal, timeBaseLow;
	ter_reset_type wdResetKind;
	int            mismatches, total_checks, resetReqs;

	ter_timer_events DUT (.sys_clk(sys_clk), .rst_n(rst_n),
		.porRst_n(porRst_n), .sprNum(sprNum), .sprWrEn(sprWrEn),
		.sprWrData(sprWrData), .sprRdEn(sprRdEn), .sprRdData(sprRdData),
		.sprRdValid(sprRdValid), .timeBaseLow(timeBaseLow),
		.timeBaseTick(timeBaseTick), .intervalEvent(intervalEvent),
		.wdTimeoutEvent(wdTimeoutEvent), .fixedEvent(fixedEvent),
		.watchdogIrq(watchdogIrq), .intervalIrq(intervalIrq),
		.fixedIrq(fixedIrq), .wdResetReq(wdResetReq),
		.wdResetKind(wdResetKind));
	ter_time_base_model u_tb (.sys_clk(sys_clk), .rst_n(rst_n),
		.tickEn(tickEn), .tbLoad(tbLoad), .tbLoadVal(tbLoadVal),
		.timeBaseLow(timeBaseLow), .timeBaseTick(timeBaseTick));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// Counted at the falling edge so the registered pulse is settled
	always @(negedge sys_clk) begin
		if (wdResetReq === 1'b1) begin
			resetReqs++;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			mismatches++;
		end
	endtask

	task automatic wr(input logic [9:0] n, input logic [31:0] d);
		sprNum = n;
		sprWrData = d;
		sprWrEn = 1'b1;
		@(negedge sys_clk);
		sprWrEn = 1'b0;
		// Idle cycle: the strobe is never dropped and raised at one time
		@(negedge sys_clk);
	endtask

	task automatic rd(input logic [9:0] n, input logic [31:0] e);
		sprNum = n;
		sprRdEn = 1'b1;
		@(negedge sys_clk);
		sprRdEn = 1'b0;
		chk(sprRdValid ? sprRdData : 32'hdead_beef, e);
		@(negedge sys_clk);
	endtask

	// Extra cycle lets the status set land before the next access
	task automatic tick(input int n);
		tickEn = 1'b1;
		repeat (n) @(negedge sys_clk);
		tickEn = 1'b0;
		@(negedge sys_clk);
	endtask

	// Preload can raise lower taps, so stale status is cleared after
	task automatic prep(input logic [31:0] v, input logic [31:0] m);
		tbLoad = 1'b1;
		tbLoadVal = v;
		@(negedge sys_clk);
		tbLoad = 1'b0;
		@(negedge sys_clk);
		wr(TER_SPR_STATUS, m);
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		#200000;
		mismatches++;
		print_verdict();
	end

	initial begin
		{rst_n, porRst_n, sprWrEn, sprRdEn, tickEn, tbLoad} = 6'h0;
		{sprNum, sprWrData, tbLoadVal} = 74'h0;
		repeat (20) @(negedge sys_clk);
		{rst_n, porRst_n} = 2'h3;
		@(negedge sys_clk);
		rd(TER_SPR_CONTROL, 32'h0);
		rd(TER_SPR_COUNTER, 32'h0);
		wr(TER_SPR_CONTROL, 32'hffff_ffff);
		rd(TER_SPR_CONTROL, 32'hffc0_0000);
		wr(TER_SPR_CONTROL, 32'h0);
		rd(TER_SPR_CONTROL, 32'h3000_0000);
		wr(TER_SPR_STATUS, 32'hffff_ffff);
		rd(TER_SPR_STATUS, 32'h0);
		$display("test control done");
		wr(TER_SPR_COUNTER, 32'h3);
		tick(2);
		rd(TER_SPR_COUNTER, 32'h1);
		tick(3);
		rd(TER_SPR_COUNTER, 32'h0);
		rd(TER_SPR_STATUS, 32'h0800_0000);
		chk({31'h0, intervalIrq}, 32'h0);
		wr(TER_SPR_STATUS, 32'hf7ff_ffff);
		rd(TER_SPR_STATUS, 32'h0800_0000);
		wr(TER_SPR_CONTROL, 32'h0400_0000);
		chk({31'h0, intervalIrq}, 32'h1);
		wr(TER_SPR_STATUS, 32'h0800_0000);
		rd(TER_SPR_STATUS, 32'h0);
		wr(TER_SPR_CONTROL, 32'h0040_0000);
		wr(TER_SPR_COUNTER, 32'h2);
		tick(2);
		rd(TER_SPR_COUNTER, 32'h2);
		rd(TER_SPR_STATUS, 32'h0800_0000);
		$display("test counter done");
		wr(TER_SPR_COUNTER, 32'h0);
		for (int k = 0; k < 4; k++) begin
			wr(TER_SPR_CONTROL, 32'hc080_0000 | (32'(k) << 24));
			prep((32'h1 << (8 + 4 * k)) - 32'h1, 32'hffff_ffff);
			tick(1);
			rd(TER_SPR_STATUS, 32'h0400_0000);
			chk({31'h0, fixedIrq}, 32'h1);
		end
		$display("test fixed done");
		for (int k = 0; k < 4; k++) begin
			wr(TER_SPR_CONTROL, (32'(k) << 30) | 32'h0800_0000);
			prep((32'h1 << (16 + 4 * k)) - 32'h1, 32'hffff_ffff);
			tick(1);
			rd(TER_SPR_STATUS, 32'h8000_0000);
		end
		prep(32'h0fff_ffff, 32'h0c00_0000);
		tick(1);
		rd(TER_SPR_STATUS, 32'hc000_0000);
		chk({31'h0, watchdogIrq}, 32'h1);
		prep(32'h0fff_ffff, 32'h0c00_0000);
		tick(1);
		rd(TER_SPR_STATUS, 32'hf000_0000);
		chk({30'h0, wdResetKind}, 32'h3);
		chk(32'(resetReqs), 32'h1);
		$display("test watchdog done");
		rst_n = 1'b0;
		repeat (2) @(negedge sys_clk);
		rst_n = 1'b1;
		@(negedge sys_clk);
		rd(TER_SPR_STATUS, 32'h3000_0000);
		rd(TER_SPR_CONTROL, 32'h0);
		$display("test reset done");
		print_verdict();
	end
endmodule
